// ---- epl_core_model.sv ----
// behavioural core that starts and ends exception service
`timescale 1ns/100ps
module epl_core_model (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // bench control
    input  wire logic              auto_take,
    input  wire logic              take_now,
    input  wire logic [3:0]        hold,
    // arbiter side
    input  wire logic              exc_pending_q,
    input  wire logic              svc_strobe_q,
    input  wire epl_pkg::epl_vec_t svc_vec_q,
    output logic                   svc_take,
    output logic                   svc_done,
    // served vector
    output logic                   got,
    output epl_pkg::epl_vec_t      got_vec
);
    import epl_pkg::*;
    logic       busy_q;
    logic [4:0] cnt_q;

    always_ff @(posedge clk) begin
        svc_take <= 1'b0;
        svc_done <= 1'b0;
        got      <= svc_strobe_q;
        if (svc_strobe_q) begin
            got_vec <= svc_vec_q;
        end
        if (srst) begin
            busy_q <= 1'b0;
            cnt_q  <= 5'h00;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else if (busy_q) begin
            svc_done <= 1'b1;
            busy_q   <= 1'b0;
            // gap so the next take never lands in the done cycle
            cnt_q    <= 5'h02;
        end else if (take_now || (auto_take && exc_pending_q)) begin
            svc_take <= 1'b1;
            busy_q   <= 1'b1;
            cnt_q    <= {1'b0, hold} + 5'h02;
        end
    end
endmodule : epl_core_model

// ---- epl_ctrl.sv ----
// exception priority arbiter with interrupt latching and an avalon-mm register slave
//
// Contract
// - each reset and interrupt owns its own 16-bit handler vector address.
// - all vectors lie in the top 128 bytes of the 64K map.
// - six highest vectors serve resets and non-maskables; lower ones serve maskables.
// - non-maskable order: reset, clock monitor, watchdog, trap, software interrupt, nmi pin.
// - nmi pin is recognised only while the X mask bit is zero.
// - maskable requests are recognised only while the global mask bit is clear.
// - global mask bit is one after reset and writable anytime.
// - highest_priority_select promotes one maskable source; others keep their order.
// - promoted source stays masked by global and local bits; vectors never move.
// - highest_priority_select accepts writes only while global mask is set.
// - nmi pin is level sensitive; external pin may be level sensitive.
// - a level request gone once service begins yields the trap vector.
// - edge mode latches an external falling edge held for the filter time.
// - the edge latch clears itself when the external interrupt is served.
// - all other sources are held pending by flags in their units.
// - edge_only_select: zero low level, one falling edge; write once normally.
// - external_pin_connect zero detaches the external pin; one connects it.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "epl_regs.svh"

module epl_ctrl #(
    parameter int NSRC = 58
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  srst,
    // avalon-mm slave
    input  wire epl_pkg::epl_avm_req_s avm_req,
    output logic [31:0]                avm_readdata_q,
    output logic                       avm_waitrequest_q,
    // mode strap, same clock
    input  wire logic                  special_mode,
    // external pins, active low
    input  wire logic                  nmi_pin_n,
    input  wire logic                  ext_irq_pin_n,
    // non-maskable and peripheral sources, same clock
    input  wire epl_pkg::epl_nmi_s     nmi_src,
    input  wire logic [NSRC-1:1]       periph_flag,
    // processor core side
    input  wire logic                  svc_take,
    input  wire logic                  svc_done,
    output logic                       exc_pending_q,
    output epl_pkg::epl_vec_t          exc_vec_q,
    output logic                       svc_strobe_q,
    output epl_pkg::epl_vec_t          svc_vec_q
);

    import epl_pkg::*;

    localparam logic [63:0] SRC_MASK = (64'h1 << NSRC) - 64'h1;

    // map a maskable source index to its vector address; index 0 is the highest
    function automatic epl_vec_t src_vec(input logic [5:0] idx);
        src_vec = {`EPL_VEC_PAGE, 8'(`EPL_VEC_IRQ_LO - {1'b0, idx, 1'b0})};
    endfunction : src_vec

    // lowest set index wins, which is the highest vector address
    function automatic logic [6:0] first_set(input logic [63:0] v);
        first_set = 7'h40;
        for (int i = 63; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 7'(i);
            end
        end
    endfunction : first_set

    // software state
    logic        cc_i_q;
    logic        cc_x_q;
    logic        edge_only_q;
    logic        edge_wr_q;
    logic [6:0]  promo_q;
    logic [63:0] en_q;
    // service state
    epl_svc_e    svc_st_q;
    epl_svc_e    svc_st_d;
    epl_vec_t    last_vec_q;
    logic        edge_latch_q;
    logic        irq_lvl_prev_q;

    // pin filtering
    logic [1:0]  pin_level_q;
    logic        nmi_active;
    logic        irq_active;

    epl_pin_filter #(
        .WIDTH (2),
        .INIT  (2'b11)
    ) u_pins (
        .clk     (clk),
        .srst    (srst),
        .pin     ({ext_irq_pin_n, nmi_pin_n}),
        .level_q (pin_level_q)
    );

    assign nmi_active = ~pin_level_q[0];
    assign irq_active = ~pin_level_q[1];

    // bus decode
    logic        bus_req;
    logic        bus_fire;
    logic        wr_fire;
    logic [4:0]  bus_ofs;

    assign bus_req  = avm_req.read | avm_req.write;
    assign bus_fire = bus_req & ~avm_waitrequest_q;
    assign wr_fire  = bus_fire & avm_req.write;
    assign bus_ofs  = {avm_req.address[4:2], 2'b00};

    // one wait cycle per access, then the answer stands for one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            avm_waitrequest_q <= 1'b1;
        end else if (bus_req & avm_waitrequest_q) begin
            avm_waitrequest_q <= 1'b0;
        end else begin
            avm_waitrequest_q <= 1'b1;
        end
    end

    // global and nonmaskable mask bits
    always_ff @(posedge clk) begin
        if (srst) begin
            cc_i_q <= `EPL_RST_I;
            cc_x_q <= `EPL_RST_X;
        end else if (wr_fire && bus_ofs == `EPL_OFS_CTRL) begin
            cc_i_q <= avm_req.writedata[`EPL_CTRL_I_BIT];
            cc_x_q <= avm_req.writedata[`EPL_CTRL_X_BIT];
        end
    end

    // edge select: first write takes in normal mode, first write is dropped in special mode
    always_ff @(posedge clk) begin
        if (srst) begin
            edge_only_q <= `EPL_RST_EDGE;
            edge_wr_q   <= 1'b0;
        end else if (wr_fire && bus_ofs == `EPL_OFS_CTRL) begin
            edge_wr_q <= 1'b1;
            if (special_mode ? edge_wr_q : ~edge_wr_q) begin
                edge_only_q <= avm_req.writedata[`EPL_CTRL_EDGE_BIT];
            end
        end
    end

    // promotion register, held in units of one vector (bit 0 always reads zero)
    always_ff @(posedge clk) begin
        if (srst) begin
            promo_q <= 7'(`EPL_RST_PROMO >> 1);
        end else if (wr_fire && bus_ofs == `EPL_OFS_PROMO && cc_i_q) begin
            promo_q <= avm_req.writedata[7:1];
        end
    end

    // local enables; bit 0 is external_pin_connect
    always_ff @(posedge clk) begin
        if (srst) begin
            en_q <= `EPL_RST_EN & SRC_MASK;
        end else if (wr_fire && bus_ofs == `EPL_OFS_EN_LO) begin
            en_q[31:0] <= avm_req.writedata & SRC_MASK[31:0];
        end else if (wr_fire && bus_ofs == `EPL_OFS_EN_HI) begin
            en_q[63:32] <= avm_req.writedata & SRC_MASK[63:32];
        end
    end

    // external request: level or latched falling edge
    logic pin_connect;
    logic irq_fall;
    logic irq_served;
    logic irq_req;

    assign pin_connect = en_q[0];
    assign irq_fall    = irq_active & ~irq_lvl_prev_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_lvl_prev_q <= 1'b0;
        end else begin
            irq_lvl_prev_q <= irq_active;
        end
    end

    // set wins over the clear by service
    always_ff @(posedge clk) begin
        if (srst) begin
            edge_latch_q <= 1'b0;
        end else if (pin_connect && edge_only_q && irq_fall) begin
            edge_latch_q <= 1'b1;
        end else if (irq_served || !edge_only_q) begin
            edge_latch_q <= 1'b0;
        end
    end

    assign irq_req = pin_connect & (edge_only_q ? edge_latch_q : irq_active);

    // maskable arbitration
    logic [63:0] raw_req;
    logic [63:0] act;
    logic [7:0]  hp_byte;
    logic [6:0]  promo_idx;
    logic        promo_ok;
    logic [6:0]  win_idx;
    logic        mask_any;
    logic [5:0]  mask_idx;

    assign raw_req = {{(64 - NSRC){1'b0}}, periph_flag, irq_req};
    assign act     = raw_req & en_q & SRC_MASK & {64{~cc_i_q}};
    assign hp_byte = {promo_q, 1'b0};

    always_comb begin
        promo_idx = 7'(8'(`EPL_VEC_IRQ_LO - hp_byte) >> 1);
        promo_ok  = (hp_byte >= `EPL_VEC_LOWEST) && (hp_byte <= `EPL_VEC_IRQ_LO) && (promo_idx < 7'(NSRC));
    end

    assign win_idx  = first_set(act);
    assign mask_any = act != 64'h0;
    assign mask_idx = (promo_ok && act[promo_idx[5:0]]) ? promo_idx[5:0] : win_idx[5:0];

    // non-maskable arbitration ahead of maskables
    logic     any_req;
    epl_vec_t win_vec;

    always_comb begin
        any_req = 1'b1;
        if (nmi_src.por) begin
            win_vec = `EPL_VEC_POR;
        end else if (nmi_src.clkmon) begin
            win_vec = `EPL_VEC_CLKMON;
        end else if (nmi_src.watchdog) begin
            win_vec = `EPL_VEC_WATCHDOG;
        end else if (nmi_src.unimpl) begin
            win_vec = `EPL_VEC_TRAP;
        end else if (nmi_src.soft_int) begin
            win_vec = `EPL_VEC_SOFT_INT;
        end else if (nmi_active && !cc_x_q) begin
            win_vec = `EPL_VEC_NMI;
        end else if (mask_any) begin
            win_vec = src_vec(mask_idx);
        end else begin
            any_req = 1'b0;
            win_vec = `EPL_VEC_TRAP;
        end
    end

    // request to the core, registered every cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            exc_pending_q <= 1'b0;
            exc_vec_q     <= `EPL_VEC_POR;
        end else begin
            exc_pending_q <= any_req;
            exc_vec_q     <= win_vec;
        end
    end

    // service sequencing
    always_comb begin
        svc_st_d = svc_st_q;
        case (svc_st_q)
            EPL_SVC_IDLE: begin
                if (svc_take) begin
                    svc_st_d = EPL_SVC_LATCH;
                end
            end
            EPL_SVC_LATCH: begin
                svc_st_d = EPL_SVC_BUSY;
            end
            EPL_SVC_BUSY: begin
                if (svc_done) begin
                    svc_st_d = EPL_SVC_IDLE;
                end
            end
            default: begin
                svc_st_d = EPL_SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            svc_st_q <= EPL_SVC_IDLE;
        end else begin
            svc_st_q <= svc_st_d;
        end
    end

    logic take_now;
    assign take_now   = (svc_st_q == EPL_SVC_IDLE) && svc_take;
    // the vector is decided when the take arrives; a vanished request falls to the trap
    assign irq_served = take_now && any_req && (win_vec == src_vec(6'h00));

    always_ff @(posedge clk) begin
        if (srst) begin
            svc_strobe_q <= 1'b0;
            svc_vec_q    <= `EPL_VEC_POR;
            last_vec_q   <= `EPL_VEC_POR;
        end else begin
            svc_strobe_q <= take_now;
            if (take_now) begin
                svc_vec_q  <= any_req ? win_vec : `EPL_VEC_TRAP;
                last_vec_q <= any_req ? win_vec : `EPL_VEC_TRAP;
            end
        end
    end

    // read data, captured in the wait cycle so it stands when waitrequest drops
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0;
        case (bus_ofs)
            `EPL_OFS_CTRL: begin
                rd_mux[`EPL_CTRL_I_BIT]    = cc_i_q;
                rd_mux[`EPL_CTRL_X_BIT]    = cc_x_q;
                rd_mux[`EPL_CTRL_EDGE_BIT] = edge_only_q;
                rd_mux[`EPL_CTRL_EDGE_WR]  = edge_wr_q;
            end
            `EPL_OFS_PROMO: begin
                rd_mux[7:0] = hp_byte;
            end
            `EPL_OFS_EN_LO: begin
                rd_mux = en_q[31:0];
            end
            `EPL_OFS_EN_HI: begin
                rd_mux = en_q[63:32];
            end
            `EPL_OFS_REQ_LO: begin
                rd_mux = raw_req[31:0];
            end
            `EPL_OFS_REQ_HI: begin
                rd_mux = raw_req[63:32];
            end
            `EPL_OFS_STATUS: begin
                rd_mux = {13'h0, svc_st_q, any_req, last_vec_q};
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avm_readdata_q <= 32'h0;
        end else if (avm_req.read && avm_waitrequest_q) begin
            avm_readdata_q <= rd_mux;
        end
    end

endmodule : epl_ctrl

// ---- epl_ctrl_asserts.sv ----
// port-level checker for the exception arbiter
`timescale 1ns/100ps
module epl_ctrl_asserts #(
    parameter int NSRC = 58
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  srst,
    // bus and sources
    input wire epl_pkg::epl_avm_req_s avm_req,
    input wire logic                  avm_waitrequest_q,
    input wire epl_pkg::epl_nmi_s     nmi_src,
    // core side
    input wire logic                  svc_take,
    input wire logic                  exc_pending_q,
    input wire epl_pkg::epl_vec_t     exc_vec_q,
    input wire logic                  svc_strobe_q,
    input wire epl_pkg::epl_vec_t     svc_vec_q
);
    import epl_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire logic req;
    assign req = avm_req.read | avm_req.write;

    sequence s_ack;
        !avm_waitrequest_q ##1 avm_waitrequest_q;
    endsequence
    sequence s_strobe_gap;
        !svc_strobe_q [*2];
    endsequence
    property p_ack_one;
        req && avm_waitrequest_q |=> s_ack;
    endproperty
    property p_idle;
        !req && avm_waitrequest_q |=> avm_waitrequest_q;
    endproperty
    property p_por;
        nmi_src.por |=> exc_pending_q && exc_vec_q == 16'hFFFE;
    endproperty
    property p_clkmon;
        nmi_src[4:3] == 2'b01 |=> exc_vec_q == 16'hFFFC;
    endproperty
    property p_soft_int;
        nmi_src == 5'h01 |=> exc_vec_q == 16'hFFF6;
    endproperty
    property p_vec;
        exc_pending_q |-> exc_vec_q[15:7] == 9'h1FF && !exc_vec_q[0];
    endproperty
    property p_strobe;
        svc_strobe_q |-> $past(svc_take) ##1 s_strobe_gap;
    endproperty
    property p_hold;
        !svc_strobe_q |-> $stable(svc_vec_q);
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("bus answer is not one cycle");
    a_idle: assert property (p_idle) else $error("waitrequest dropped with no request");
    a_por: assert property (p_por) else $error("reset vector did not win");
    a_clkmon: assert property (p_clkmon) else $error("clock monitor vector wrong");
    a_soft_int: assert property (p_soft_int) else $error("software interrupt vector wrong");
    a_vec: assert property (p_vec) else $error("vector outside top page");
    a_strobe: assert property (p_strobe) else $error("service strobe without take");
    a_hold: assert property (p_hold) else $error("served vector moved without take");
endmodule : epl_ctrl_asserts

bind epl_ctrl epl_ctrl_asserts #(.NSRC(NSRC)) u_asserts (
    .clk(clk), .srst(srst), .avm_req(avm_req), .avm_waitrequest_q(avm_waitrequest_q),
    .nmi_src(nmi_src), .svc_take(svc_take), .exc_pending_q(exc_pending_q),
    .exc_vec_q(exc_vec_q), .svc_strobe_q(svc_strobe_q), .svc_vec_q(svc_vec_q)
);

// ---- epl_pin_filter.sv ----
// three-stage pin synchroniser with agreement filter, one lane per pin
`timescale 1ns/100ps
`include "epl_regs.svh"

module epl_pin_filter #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // pins and filtered levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level_q
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            logic [`EPL_SYNC_STAGES-1:0] sh_q;
            logic                        lvl_q;
            always_ff @(posedge clk) begin
                if (srst) begin
                    sh_q <= {`EPL_SYNC_STAGES{INIT[g]}};
                end else begin
                    sh_q <= {sh_q[`EPL_SYNC_STAGES-2:0], pin[g]};
                end
            end
            // stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
            always_ff @(posedge clk) begin
                if (srst) begin
                    lvl_q <= INIT[g];
                end else if (sh_q[1] == sh_q[2]) begin
                    lvl_q <= sh_q[2];
                end
            end
            // one flop per lane keeps every always_ff the only writer of its variable
            assign level_q[g] = lvl_q;
        end
    endgenerate

endmodule : epl_pin_filter

// ---- epl_pkg.sv ----
// types shared by the exception arbiter files
package epl_pkg;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } epl_avm_req_s;

    typedef struct packed {
        logic por;
        logic clkmon;
        logic watchdog;
        logic unimpl;
        logic soft_int;
    } epl_nmi_s;

    typedef enum logic [1:0] {
        EPL_SVC_IDLE  = 2'b00,
        EPL_SVC_LATCH = 2'b01,
        EPL_SVC_BUSY  = 2'b11
    } epl_svc_e;

    typedef logic [15:0] epl_vec_t;

endpackage : epl_pkg

// ---- epl_regs.svh ----
// register offsets, field positions, reset values and vector constants of the exception arbiter
`ifndef EPL_REGS_SVH
`define EPL_REGS_SVH

// byte offsets on the register bus
`define EPL_OFS_CTRL        5'h00
`define EPL_OFS_PROMO       5'h04
`define EPL_OFS_EN_LO       5'h08
`define EPL_OFS_EN_HI       5'h0C
`define EPL_OFS_REQ_LO      5'h10
`define EPL_OFS_REQ_HI      5'h14
`define EPL_OFS_STATUS      5'h18

// control register fields
`define EPL_CTRL_I_BIT      0
`define EPL_CTRL_X_BIT      1
`define EPL_CTRL_EDGE_BIT   2
`define EPL_CTRL_EDGE_WR    3

// reset values
`define EPL_RST_I           1'b1
`define EPL_RST_X           1'b1
`define EPL_RST_EDGE        1'b0
`define EPL_RST_CONNECT     1'b1
`define EPL_RST_PROMO       8'hF2
`define EPL_RST_EN          64'h0000000000000001

// vector space: top 128 bytes of the 64K map
`define EPL_VEC_SPACE_BYTES 128
`define EPL_VEC_PAGE        8'hFF
`define EPL_VEC_LOWEST      8'h80
`define EPL_VEC_POR         16'hFFFE
`define EPL_VEC_CLKMON      16'hFFFC
`define EPL_VEC_WATCHDOG    16'hFFFA
`define EPL_VEC_TRAP        16'hFFF8
`define EPL_VEC_SOFT_INT    16'hFFF6
`define EPL_VEC_NMI         16'hFFF4
`define EPL_VEC_IRQ_LO      8'hF2

// pin filter depth
`define EPL_SYNC_STAGES     3

`endif

// ---- exception_priority_and_latching_bench.sv ----
// self-checking bench for the exception arbiter
`timescale 1ns/100ps
`include "epl_regs.svh"
module exception_priority_and_latching_bench;
    import epl_pkg::*;
    logic         clk, srst, nmi_pin_n, ext_irq_pin_n, auto_take, take_now, special_mode;
    logic         svc_take, svc_done, exc_pending_q, svc_strobe_q, got, avm_waitrequest_q;
    logic [31:0]  avm_readdata_q, rdata;
    logic [31:0]  seed = 32'h0000_0677;
    logic [57:1]  flag;
    logic [57:0]  en, m;
    epl_avm_req_s req;
    epl_nmi_s     nmi;
    epl_vec_t     exc_vec_q, svc_vec_q, got_vec;
    int           fails = 0;
    int           comparisons = 0;
    int           p;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    epl_ctrl dut (.clk(clk), .srst(srst), .avm_req(req), .avm_readdata_q(avm_readdata_q),
        .avm_waitrequest_q(avm_waitrequest_q), .special_mode(special_mode), .nmi_pin_n(nmi_pin_n),
        .ext_irq_pin_n(ext_irq_pin_n), .nmi_src(nmi), .periph_flag(flag), .svc_take(svc_take),
        .svc_done(svc_done), .exc_pending_q(exc_pending_q), .exc_vec_q(exc_vec_q),
        .svc_strobe_q(svc_strobe_q), .svc_vec_q(svc_vec_q));
    epl_core_model core (.clk(clk), .srst(srst), .auto_take(auto_take), .take_now(take_now),
        .hold(4'h3), .exc_pending_q(exc_pending_q), .svc_strobe_q(svc_strobe_q),
        .svc_vec_q(svc_vec_q), .svc_take(svc_take), .svc_done(svc_done), .got(got),
        .got_vec(got_vec));

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // promoted source first, then lowest index (highest vector)
    function automatic logic [15:0] exp_vec(input logic [57:0] r, input int pr);
        if (r[pr]) return 16'hFFF2 - 16'(2 * pr);
        for (int i = 0; i < 58; i++) if (r[i]) return 16'hFFF2 - 16'(2 * i);
        return 16'hFFF8;
    endfunction : exp_vec

    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, writedata: d};
        @(posedge clk);
        for (n = 0; n < 20 && avm_waitrequest_q !== 1'b0; n++) @(posedge clk);
        if (n == 20) begin
            fails++;
            end_of_test();
        end
        rdata = avm_readdata_q;
        req <= '0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdata);
    endtask : rd

    task automatic wait_got(input logic [15:0] e);
        int n;
        for (n = 0; n < 100 && got !== 1'b1; n++) @(negedge clk);
        if (n == 100) begin
            fails++;
            end_of_test();
        end
        chk("served vector", e, got_vec);
    endtask : wait_got

    task automatic pulse(input logic nmi_line);
        @(posedge clk);
        if (nmi_line) nmi_pin_n <= ~nmi_pin_n;
        else ext_irq_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_irq_pin_n <= 1'b1;
        repeat (12) @(negedge clk);
    endtask : pulse

    initial begin
        {srst, nmi_pin_n, ext_irq_pin_n} = 3'h7;
        {auto_take, take_now, special_mode, req, nmi, flag} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`EPL_OFS_CTRL, 32'h3, "ctrl reset");
        rd(`EPL_OFS_PROMO, 32'hF2, "promotion reset");
        rd(`EPL_OFS_EN_LO, 32'h1, "enable low reset");
        rd(`EPL_OFS_EN_HI, 32'h0, "enable high reset");
        rd(5'h1C, 32'h0, "unmapped");
        bus(1'b1, `EPL_OFS_CTRL, 32'h7);
        bus(1'b0, `EPL_OFS_CTRL, 32'h0);
        chk("edge select", 32'h7, rdata & 32'h7);
        $display("reset values done");
        for (int k = 0; k < 5; k++) begin
            p = 16 >> k;
            @(posedge clk);
            nmi <= 5'(p | (rnd() & (p - 1)));
            repeat (2) @(negedge clk);
            chk("nmi winner", 32'hFFFE - 2 * k, exc_vec_q);
        end
        @(posedge clk) nmi <= '0;
        pulse(1'b1);
        chk("nmi pin masked", 32'h0, exc_pending_q);
        bus(1'b1, `EPL_OFS_CTRL, 32'h5);
        repeat (4) @(negedge clk);
        chk("nmi pin level", 32'hFFF4, exc_vec_q);
        pulse(1'b1);
        @(posedge clk);
        take_now <= 1'b1;
        @(posedge clk);
        take_now <= 1'b0;
        wait_got(16'hFFF8);
        $display("non-maskable test done");
        for (int it = 0; it < 8; it++) begin
            bus(1'b1, `EPL_OFS_CTRL, 32'h7);
            flag <= '0;
            p = rnd() % 58;
            bus(1'b1, `EPL_OFS_PROMO, 32'hF2 - 2 * p);
            en = 58'({rnd(), rnd()}) | 58'h1;
            bus(1'b1, `EPL_OFS_EN_LO, en[31:0]);
            bus(1'b1, `EPL_OFS_EN_HI, {6'h00, en[57:32]});
            flag <= 57'({rnd(), rnd()} & {rnd(), rnd()} & {rnd(), rnd()});
            repeat (3) @(negedge clk);
            chk("masked pending", 32'h0, exc_pending_q);
            bus(1'b1, `EPL_OFS_CTRL, 32'h6);
            bus(1'b1, `EPL_OFS_PROMO, 32'h80);
            rd(`EPL_OFS_PROMO, 32'hF2 - 2 * p, "promotion kept");
            m = {flag, 1'b0} & en;
            chk("pending", 32'(m != 0), exc_pending_q);
            if (m != 0) chk("maskable winner", exp_vec(m, p), exc_vec_q);
            rd(`EPL_OFS_REQ_LO, {flag[31:1], 1'b0}, "request low");
            rd(`EPL_OFS_REQ_HI, 32'(flag[57:32]), "request high");
        end
        $display("maskable test done");
        bus(1'b1, `EPL_OFS_CTRL, 32'h7);
        flag <= '0;
        bus(1'b1, `EPL_OFS_EN_LO, 32'h1);
        bus(1'b1, `EPL_OFS_EN_HI, 32'h0);
        bus(1'b1, `EPL_OFS_CTRL, 32'h6);
        pulse(1'b0);
        chk("edge latched", 32'hFFF2, exc_vec_q);
        @(posedge clk) auto_take <= 1'b1;
        wait_got(16'hFFF2);
        repeat (10) @(negedge clk);
        chk("edge latch cleared", 32'h0, exc_pending_q);
        rd(`EPL_OFS_STATUS, 32'h0000FFF2, "service status");
        auto_take <= 1'b0;
        bus(1'b1, `EPL_OFS_CTRL, 32'h7);
        bus(1'b1, `EPL_OFS_EN_LO, 32'h0);
        bus(1'b1, `EPL_OFS_CTRL, 32'h2);
        pulse(1'b0);
        chk("pin disconnected", 32'h0, exc_pending_q);
        bus(1'b0, `EPL_OFS_CTRL, 32'h0);
        chk("edge select locked", 32'h4, rdata & 32'h4);
        $display("external pin test done");
        // second reset in special mode: the first edge select write is dropped, later ones land
        srst <= 1'b1;
        special_mode <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        bus(1'b1, `EPL_OFS_CTRL, 32'h7);
        rd(`EPL_OFS_CTRL, 32'hB, "special first write");
        bus(1'b1, `EPL_OFS_CTRL, 32'h7);
        rd(`EPL_OFS_CTRL, 32'hF, "special second write");
        $display("special mode test done");
        end_of_test();
    end
endmodule : exception_priority_and_latching_bench
